// *** hw/getd_detector.sv ***
// How it works
// - after power-up the output sits in the off state, reading high.
// - in the reference direction the output rises at a tooth's edge.
// - reversed rotation inverts tooth presence against output level.
// - start-up calibration ends within six detected edges.
// - the second detected edge always moves the output.
// - the first falling transition after power-up is made correctly.
// - a bad supply forces and holds the output in the off state.
// - each power-up measures the span and fixes the gain from it.
// - captured peak and valley values are the comparison reference.
// - thresholds sit at 30% and 70% of the valley-to-peak span.
// - running thresholds come from the two preceding edges' extremes.
`timescale 1ns/1ps

module getd_detector
  import getd_pkg::*;
#(
  parameter int SAMPLE_W = 12,
  parameter int MIN_SPAN = 64
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid_in,
  input wire logic supply_good_in,
  output logic sensor_output_out,
  output logic sensor_pin_out,
  output logic sensor_pin_oe_n_out,
  output logic calibrated_out,
  output logic [GETD_GAIN_W-1:0] gain_normalizer_out,
  output logic [SAMPLE_W+GETD_GAIN_MAX-1:0] operate_threshold_out,
  output logic [SAMPLE_W+GETD_GAIN_MAX-1:0] release_threshold_out
);

  localparam int NW = SAMPLE_W + GETD_GAIN_MAX;
  localparam int PW = NW + 7;
  localparam logic [SAMPLE_W-1:0] MIN_SPAN_V = SAMPLE_W'(MIN_SPAN);

  // ==========================================================
  // reset release and supply-good synchronisers
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic sup_meta_ff;
  logic sup_ok_ff;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sup_meta_ff <= GETD_SUPPLY_RST;
      sup_ok_ff <= GETD_SUPPLY_RST;
    end else begin
      sup_meta_ff <= supply_good_in;
      sup_ok_ff <= sup_meta_ff;
    end
  end

  // ==========================================================
  // peak and valley trackers
  getd_track_if #(.W(SAMPLE_W)) max_trk ();
  getd_track_if #(.W(SAMPLE_W)) min_trk ();

  getd_extreme_track #(.W(SAMPLE_W), .FIND_MAX(1'b1)) u_max (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .trk(max_trk)
  );
  getd_extreme_track #(.W(SAMPLE_W), .FIND_MAX(1'b0)) u_min (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .trk(min_trk)
  );

  // ==========================================================
  // state
  getd_state_e state_ff, nxt_state;
  logic out_ff, nxt_out;
  logic [SAMPLE_W-1:0] peak_ff, nxt_peak;
  logic [SAMPLE_W-1:0] valley_ff, nxt_valley;
  logic [GETD_GAIN_W-1:0] gain_ff, nxt_gain;
  logic [GETD_EDGE_CNT_W-1:0] edge_cnt_ff, nxt_edge_cnt;
  logic [NW-1:0] op_thr_ff, rp_thr_ff;

  logic [SAMPLE_W-1:0] ref_peak, ref_valley, span, diff, cur_max, cur_min;
  logic [GETD_GAIN_W-1:0] ref_gain;
  logic [NW-1:0] span_n, norm, op_thr, rp_thr;
  logic [PW-1:0] op_full, rp_full;
  logic rise, fall, restart_max, restart_min;

  // largest shift that keeps the normalised span inside the sample range
  function automatic logic [GETD_GAIN_W-1:0] gain_of(
    input logic [SAMPLE_W-1:0] s);
    logic [GETD_GAIN_W-1:0] g;
    g = '0;
    for (int k = 1; k <= GETD_GAIN_MAX; k++) begin
      if ((NW'(s) << k) < (NW'(1) << SAMPLE_W)) begin
        g = GETD_GAIN_W'(k);
      end
    end
    return g;
  endfunction

  // ==========================================================
  // normalised signal and hysteretic thresholds
  always_comb begin
    // calibration judges each sample against a span that includes it
    cur_max = (sample_valid_in && sample_in > max_trk.value)
              ? sample_in : max_trk.value;
    cur_min = (sample_valid_in && sample_in < min_trk.value)
              ? sample_in : min_trk.value;
    if (state_ff == ST_RUN) begin
      ref_peak = peak_ff;
      ref_valley = valley_ff;
      ref_gain = gain_ff;
    end else begin
      ref_peak = cur_max;
      ref_valley = cur_min;
      ref_gain = '0;
    end
    span = (ref_peak > ref_valley) ? ref_peak - ref_valley : '0;
    diff = (sample_in > ref_valley) ? sample_in - ref_valley : '0;
    span_n = NW'(span) << ref_gain;
    norm = NW'(diff) << ref_gain;
    op_full = (PW'(span_n) * PW'(GETD_OP_PCT)) / PW'(GETD_PCT_FULL);
    rp_full = (PW'(span_n) * PW'(GETD_RP_PCT)) / PW'(GETD_PCT_FULL);
    op_thr = op_full[NW-1:0];
    rp_thr = rp_full[NW-1:0];
    // a reversed target mirrors the signal, so the level inverts too
    rise = !out_ff && sample_valid_in && span != '0
           && norm > op_thr;
    fall = out_ff && sample_valid_in && span != '0
           && norm < rp_thr;
  end

  // ==========================================================
  // power, calibration and running control
  always_comb begin
    nxt_state = state_ff;
    nxt_out = out_ff;
    nxt_peak = peak_ff;
    nxt_valley = valley_ff;
    nxt_gain = gain_ff;
    nxt_edge_cnt = edge_cnt_ff;
    restart_max = 1'b0;
    restart_min = 1'b0;
    case (state_ff)
      ST_OFF: begin
        restart_max = 1'b1;
        restart_min = 1'b1;
        nxt_out = GETD_OUT_OFF;
        nxt_edge_cnt = '0;
        if (sup_ok_ff) begin
          nxt_state = ST_CAL;
        end
      end
      ST_CAL: begin
        if (rise || fall) begin
          nxt_out = rise;
          nxt_edge_cnt = edge_cnt_ff + 1'b1;
          if (span >= MIN_SPAN_V ||
              nxt_edge_cnt == GETD_EDGE_CNT_W'(GETD_CAL_EDGES_MAX)) begin
            nxt_state = ST_RUN;
            nxt_peak = cur_max;
            nxt_valley = cur_min;
            nxt_gain = gain_of(span);
            restart_min = rise;
            restart_max = fall;
          end
        end
      end
      ST_RUN: begin
        if (rise) begin
          nxt_out = 1'b1;
          nxt_valley = min_trk.value;
          restart_min = 1'b1;
        end else if (fall) begin
          nxt_out = 1'b0;
          nxt_peak = max_trk.value;
          restart_max = 1'b1;
        end
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
    if (!sup_ok_ff) begin
      nxt_state = ST_OFF;
      nxt_out = GETD_OUT_OFF;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_OFF;
      out_ff <= GETD_OUT_OFF;
      peak_ff <= '0;
      valley_ff <= '0;
      gain_ff <= '0;
      edge_cnt_ff <= '0;
      op_thr_ff <= '0;
      rp_thr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      out_ff <= nxt_out;
      peak_ff <= nxt_peak;
      valley_ff <= nxt_valley;
      gain_ff <= nxt_gain;
      edge_cnt_ff <= nxt_edge_cnt;
      op_thr_ff <= op_thr;
      rp_thr_ff <= rp_thr;
    end
  end

  // ==========================================================
  // tracker hookup
  assign max_trk.restart = restart_max;
  assign max_trk.valid = sample_valid_in;
  assign max_trk.sample = sample_in;
  assign min_trk.restart = restart_min;
  assign min_trk.valid = sample_valid_in;
  assign min_trk.sample = sample_in;

  // ==========================================================
  // outputs; open-drain pin pulls low while the output is on
  assign sensor_output_out = out_ff;
  assign sensor_pin_out = 1'b0;
  assign sensor_pin_oe_n_out = out_ff;
  assign calibrated_out = (state_ff == ST_RUN);
  assign gain_normalizer_out = gain_ff;
  assign operate_threshold_out = op_thr_ff;
  assign release_threshold_out = rp_thr_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  a_off_when_idle: assert property (
    state_ff == ST_OFF |-> sensor_output_out)
    else $error("output not off while powered down");
  a_undervolt_off: assert property (
    !sup_ok_ff |=> state_ff == ST_OFF && sensor_output_out)
    else $error("undervoltage did not force the off state");
  a_rise_cross_op: assert property (
    ($rose(out_ff) && state_ff != ST_OFF)
    |-> $past(norm > op_thr && sample_valid_in))
    else $error("output rose without crossing operate threshold");
  a_fall_cross_rp: assert property (
    $fell(out_ff) |-> $past(norm < rp_thr && sample_valid_in))
    else $error("output fell without crossing release threshold");
  a_cal_edge_bound: assert property (
    state_ff == ST_CAL
    |-> edge_cnt_ff < GETD_EDGE_CNT_W'(GETD_CAL_EDGES_MAX))
    else $error("calibration ran past its edge limit");
  a_cal_edge_moves: assert property (
    (state_ff == ST_CAL && edge_cnt_ff != nxt_edge_cnt && sup_ok_ff)
    |=> $changed(out_ff))
    else $error("counted edge did not move the output");
  a_thr_ordered: assert property (
    state_ff == ST_RUN |-> rp_thr <= op_thr)
    else $error("release threshold above operate threshold");
  a_hyst_hold: assert property (
    (state_ff == ST_RUN && sup_ok_ff && norm >= rp_thr && norm <= op_thr)
    |=> $stable(out_ff))
    else $error("output moved inside the hysteresis band");
  a_peak_on_fall: assert property (
    (state_ff == ST_RUN && fall && sup_ok_ff)
    |=> peak_ff == $past(max_trk.value))
    else $error("peak not captured at falling edge");
  a_gain_fixed: assert property (
    (state_ff == ST_RUN && $past(state_ff) == ST_RUN)
    |-> $stable(gain_ff))
    else $error("gain changed while running");

  c_cal_done: cover property ($rose(calibrated_out));
  c_run_rise: cover property (state_ff == ST_RUN && rise);
  c_first_fall: cover property (state_ff == ST_CAL && fall
                                && edge_cnt_ff == '0);
  c_undervolt_run: cover property (state_ff == ST_RUN && !sup_ok_ff);

endmodule

// *** hw/getd_extreme_track.sv ***
`timescale 1ns/1ps

// ==========================================================
// running maximum or minimum of the sample stream
module getd_extreme_track
  import getd_pkg::*;
#(
  parameter int W = 12,
  parameter bit FIND_MAX = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  getd_track_if.tracker trk
);

  localparam logic [W-1:0] SEED = FIND_MAX ? '0 : '1;

  logic [W-1:0] value_ff;
  logic [W-1:0] nxt_value;
  logic better;

  // restart seeds from the current sample, or from SEED when no sample is valid, else keeps the extreme
  always_comb begin
    better = FIND_MAX ? (trk.sample > value_ff) : (trk.sample < value_ff);
    nxt_value = value_ff;
    if (trk.restart) begin
      nxt_value = trk.valid ? trk.sample : SEED;
    end else if (trk.valid && better) begin
      nxt_value = trk.sample;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      value_ff <= SEED;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign trk.value = value_ff;

  // ==========================================================
  // checks
  a_extreme_monotone: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    !$past(trk.restart) |-> (FIND_MAX ? value_ff >= $past(value_ff)
                                      : value_ff <= $past(value_ff)))
    else $error("tracked extreme moved the wrong way");

endmodule

// *** hw/getd_pkg.sv ***
package getd_pkg;

  // ==========================================================
  // switching thresholds, percent of normalised peak-to-peak
  localparam int GETD_OP_PCT = 70;
  localparam int GETD_RP_PCT = 30;
  localparam int GETD_PCT_FULL = 100;

  // ==========================================================
  // start-up calibration, counted in detected edges
  localparam int GETD_CAL_EDGES_MAX = 6;
  localparam int GETD_CAL_EDGES_TYP = 2;
  localparam int GETD_EDGE_CNT_W = 3;

  // ==========================================================
  // gain normaliser: left shift applied to the tracked span
  localparam int GETD_GAIN_MAX = 7;
  localparam int GETD_GAIN_W = 3;

  // ==========================================================
  // reset values
  localparam logic GETD_OUT_OFF = 1'b1;
  localparam logic GETD_SUPPLY_RST = 1'b0;

  typedef enum logic [1:0] {ST_OFF, ST_CAL, ST_RUN} getd_state_e;

endpackage

// *** hw/getd_track_if.sv ***
`timescale 1ns/1ps

// ==========================================================
// link between the detector and one extreme tracker
interface getd_track_if #(parameter int W = 12);
  logic restart;
  logic valid;
  logic [W-1:0] sample;
  logic [W-1:0] value;

  modport owner (output restart, output valid, output sample,
                 input value);
  modport tracker (input restart, input valid, input sample,
                   output value);
endinterface

// *** testbench/getd_ctrl_model.sv ***
`timescale 1ns/1ps

// ==========================================================
// controller input with pull-up reading the open-drain pin
module getd_ctrl_model (
  input wire logic pin_in,
  input wire logic pin_oe_n_in,
  output logic level_out
);
  // a released pin floats to the pull-up level
  assign level_out = pin_oe_n_in ? 1'b1 : pin_in;
endmodule

// *** testbench/tb_gear_edge_threshold_detector.sv ***
`timescale 1ns/1ps

// compare two values, count and report
`define CHK(a, e) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end

module tb_gear_edge_threshold_detector import getd_pkg::*;;
  logic core_clk_in;
  logic arst_n_in;
  logic [11:0] sample_in;
  logic sample_valid_in;
  logic supply_good_in;
  logic sensor_output_out;
  logic sensor_pin_out;
  logic sensor_pin_oe_n_out;
  logic calibrated_out;
  logic [GETD_GAIN_W-1:0] gain_normalizer_out;
  logic [18:0] operate_threshold_out;
  logic [18:0] release_threshold_out;
  logic pin_level;
  int n_fail;
  int comparisons;

  // ==========================================================
  // device and pin reader
  getd_detector #(.SAMPLE_W(12), .MIN_SPAN(64)) u_dut (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .sample_in(sample_in),
    .sample_valid_in(sample_valid_in),
    .supply_good_in(supply_good_in),
    .sensor_output_out(sensor_output_out),
    .sensor_pin_out(sensor_pin_out),
    .sensor_pin_oe_n_out(sensor_pin_oe_n_out),
    .calibrated_out(calibrated_out),
    .gain_normalizer_out(gain_normalizer_out),
    .operate_threshold_out(operate_threshold_out),
    .release_threshold_out(release_threshold_out)
  );

  getd_ctrl_model u_ctrl (
    .pin_in(sensor_pin_out),
    .pin_oe_n_in(sensor_pin_oe_n_out),
    .level_out(pin_level)
  );

  // 50 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  // ==========================================================
  // helpers
  task automatic send(input logic [11:0] s);
    @(posedge core_clk_in);
    sample_in <= s;
    sample_valid_in <= 1'b1;
    @(posedge core_clk_in);
    sample_valid_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic chk_out(input logic e);
    `CHK(sensor_output_out, e)
    `CHK(pin_level, e)
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    #1;
    chk_out(GETD_OUT_OFF);
    `CHK(calibrated_out, 1'b0)
  endtask

  // first rising crossing is lost, the falling one is made
  task automatic t_startup();
    send(12'hc00);
    chk_out(1'b1);
    send(12'h400);
    chk_out(1'b0);
    `CHK(calibrated_out, 1'b1)
    `CHK(gain_normalizer_out, 3'h0)
    `CHK(operate_threshold_out, 19'h599)
    `CHK(release_threshold_out, 19'h266)
  endtask

  // threshold boundaries and the band between them
  task automatic t_hyst();
    send(12'hc00);
    chk_out(1'b1);
    send(12'h666);
    chk_out(1'b1);
    send(12'h800);
    chk_out(1'b1);
    send(12'h665);
    chk_out(1'b0);
    send(12'h999);
    chk_out(1'b0);
    send(12'h99a);
    chk_out(1'b1);
  endtask

  // new extremes of the last two edges set the thresholds
  task automatic t_update();
    send(12'h665);
    chk_out(1'b0);
    @(posedge core_clk_in);
    #1;
    `CHK(operate_threshold_out, 19'h23e)
    `CHK(release_threshold_out, 19'h0f6)
  endtask

  // mirrored signal for reversed rotation inverts the output
  task automatic t_direction();
    logic [1:0] pat;
    pat = 2'b10;
    for (int r = 0; r < 2; r++) begin
      for (int i = 1; i >= 0; i--) begin
        send((pat[i] ^ r[0]) ? 12'h99a : 12'h665);
        `CHK(sensor_output_out, pat[i] ^ r[0])
      end
    end
  endtask

  // lockout forces off, recovery recalibrates a small span
  task automatic t_supply();
    int edges;
    logic prev;
    send(12'h665);
    chk_out(1'b0);
    supply_good_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    #1;
    chk_out(GETD_OUT_OFF);
    send(12'h400);
    send(12'hc00);
    send(12'h400);
    chk_out(GETD_OUT_OFF);
    `CHK(calibrated_out, 1'b0)
    supply_good_in <= 1'b1;
    repeat (8) @(posedge core_clk_in);
    edges = 0;
    prev = sensor_output_out;
    for (int i = 0; i < 12 && calibrated_out !== 1'b1; i++) begin
      send(i[0] ? 12'h800 : 12'h828);
      if (sensor_output_out !== prev) edges++;
      prev = sensor_output_out;
    end
    `CHK(calibrated_out, 1'b1)
    `CHK(edges <= GETD_CAL_EDGES_MAX, 1'b1)
    `CHK(gain_normalizer_out, 3'h6)
  endtask

  // ==========================================================
  // main sequence
  initial begin
    arst_n_in = 1'b0;
    sample_in = 12'h000;
    sample_valid_in = 1'b0;
    supply_good_in = 1'b1;
    n_fail = 0;
    comparisons = 0;
    repeat (7) @(posedge core_clk_in);
    t_reset();
    @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    repeat (8) @(posedge core_clk_in);
    t_startup();
    t_hyst();
    t_update();
    t_direction();
    t_supply();
    conclude();
  end

  // watchdog, far beyond the hundred or so cycles needed
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_fail++;
    conclude();
  end
endmodule
